/* design/rtc_cfg.svh */
// constants for the rtc run control and time readout block
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
`define SYS_CLK_MHZ      125
`define BUSY_TIME_US     62500
`define TICKS_PER_SEC    256
`define PRESC_W          16
`define BUSY_W           24
`define SEC_LAST         6'h3b
`define MIN_LAST         6'h3b
`define HR24_LAST        5'h17
`define HR12_LAST        5'h0b
`define WK_LAST          3'h6
`define SEL_SECONDS      3'h0
`define SEL_MINUTES      3'h1
`define SEL_HOURS        3'h2
`define SEL_WEEKDAY      3'h3
`define SEL_FORMAT       3'h4
`define SEL_SOURCE       3'h5
`define SEL_CONTROL_TWO  3'h6
`define FMT_H12_BIT      0
`define FMT_PM_BIT       1
`define MISMATCH_MAX     2'h2
`endif

/* design/rtc_pkg.sv */
// types shared by the rtc run control block
package rtc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_BUSY = 3'b010,
      ST_DONE = 3'b100
   } upd_state_e;
endpackage

/* design/start_sync.sv */
// two-stage carry of the start bit into the count-source tick domain
`timescale 1ns/100ps
`include "rtc_cfg.svh"
module start_sync (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic srst,
   // count source and level in
   input  wire logic tick,
   input  wire logic start_in,
   // synchronised level out
   output logic      status_out
);
   logic stage_one;
   logic next_stage_one;
   logic next_status_out;

   // both stages advance only on a count-source cycle, so the flag lags by up to two
   always_comb begin
      next_stage_one  = stage_one;
      next_status_out = status_out;
      if (tick) begin
         next_stage_one  = start_in;
         next_status_out = stage_one;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         stage_one  <= 1'b0;
         status_out <= 1'b0;
      end else begin
         stage_one  <= next_stage_one;
         status_out <= next_status_out;
      end
   end
endmodule

/* design/rtc_run_control.sv */
// rtc run control, stopped-only configuration and coherent time update
// Operation
// - start bit set, status flag rises within two ticks
// - start bit cleared, status flag falls within two ticks
// - stopped means start bit and status both zero
// - busy flag high while time data updates
// - busy holds about 62.5 ms once risen
// - time updates independently of bus reads
// - irq request flag set on each update
`timescale 1ns/100ps
`include "rtc_cfg.svh"
module rtc_run_control #(
   parameter int BUSY_CYCLES   = `BUSY_TIME_US * `SYS_CLK_MHZ,
   parameter int TICKS_PER_SEC = `TICKS_PER_SEC
) (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       srst,
   // count sources, one pulse per source cycle
   input  wire logic [3:0] count_ticks,
   // run control
   input  wire logic       count_start_bit,
   output logic            count_status_flag,
   output logic            timer_stopped,
   // configuration writes
   input  wire logic       wr_en,
   input  wire logic [2:0] wr_sel,
   input  wire logic [7:0] wr_data,
   output logic            wr_refused,
   // time registers and flags
   output logic [5:0]      seconds_reg,
   output logic [5:0]      minutes_reg,
   output logic [4:0]      hours_reg,
   output logic [2:0]      weekday_reg,
   output logic            hour_format_bit,
   output logic            afternoon_bit,
   output logic [3:0]      count_source_bits,
   output logic [7:0]      timer_control_two,
   output logic            update_busy_flag,
   // interrupt request flag
   input  wire logic       irq_clear,
   output logic            irq_request_flag
);
   logic                   tick;
   logic                   sync_flag;
   logic [`PRESC_W-1:0]    presc;
   logic [`PRESC_W-1:0]    next_presc;
   logic [`BUSY_W-1:0]     busy_cnt;
   logic [`BUSY_W-1:0]     next_busy_cnt;
   rtc_pkg::upd_state_e    state;
   rtc_pkg::upd_state_e    next_state;
   logic [5:0]             next_seconds;
   logic [5:0]             next_minutes;
   logic [4:0]             next_hours;
   logic [2:0]             next_weekday;
   logic                   next_format;
   logic                   next_pm;
   logic [3:0]             next_source;
   logic [7:0]             next_ctl_two;
   logic                   next_busy;
   logic                   next_irq;
   logic                   next_stopped;
   logic                   next_refused;
   logic                   wr_ok;
   logic                   update_now;
   logic                   hr_wrap;

   // low two select bits pick one of four sources; upper bits are stored only
   assign tick = count_ticks[count_source_bits[1:0]];

   start_sync u_sync (
      .sys_clk    (sys_clk),
      .srst       (srst),
      .tick       (tick),
      .start_in   (count_start_bit),
      .status_out (sync_flag)
   );
   assign count_status_flag = sync_flag;

   // writes land only while stopped; others are dropped and flagged
   assign wr_ok = wr_en && timer_stopped;

   always_comb begin
      next_stopped = !count_start_bit && !sync_flag;
      next_refused = wr_en && !timer_stopped;
   end

   // second prescaler and update sequencer; counting follows the status flag
   always_comb begin
      next_presc    = presc;
      next_busy_cnt = busy_cnt;
      next_state    = state;
      next_busy     = update_busy_flag;
      update_now    = 1'b0;
      if (sync_flag && tick) begin
         if (presc == `PRESC_W'(TICKS_PER_SEC - 1)) begin
            next_presc = '0;
         end else begin
            next_presc = presc + `PRESC_W'(1);
         end
      end
      unique case (state)
         rtc_pkg::ST_IDLE: begin
            // a second boundary during an update is skipped rather than queued
            if (sync_flag && tick && presc == `PRESC_W'(TICKS_PER_SEC - 1)) begin
               next_state    = rtc_pkg::ST_BUSY;
               next_busy     = 1'b1;
               next_busy_cnt = '0;
            end
         end
         rtc_pkg::ST_BUSY: begin
            if (busy_cnt == `BUSY_W'(BUSY_CYCLES - 1)) begin
               next_state = rtc_pkg::ST_DONE;
            end else begin
               next_busy_cnt = busy_cnt + `BUSY_W'(1);
            end
         end
         rtc_pkg::ST_DONE: begin
            update_now = 1'b1;
            next_busy  = 1'b0;
            next_state = rtc_pkg::ST_IDLE;
         end
      endcase
   end

   // time data: advanced only at the end of busy, written only while stopped
   always_comb begin
      next_seconds = seconds_reg;
      next_minutes = minutes_reg;
      next_hours   = hours_reg;
      next_weekday = weekday_reg;
      next_format  = hour_format_bit;
      next_pm      = afternoon_bit;
      next_source  = count_source_bits;
      next_ctl_two = timer_control_two;
      hr_wrap      = hours_reg == (hour_format_bit ? `HR12_LAST : `HR24_LAST);
      if (update_now) begin
         next_seconds = seconds_reg + 6'h01;
         if (seconds_reg == `SEC_LAST) begin
            next_seconds = 6'h00;
            next_minutes = minutes_reg + 6'h01;
            if (minutes_reg == `MIN_LAST) begin
               next_minutes = 6'h00;
               next_hours   = hours_reg + 5'h01;
               if (hr_wrap) begin
                  next_hours = 5'h00;
                  // in 12-hour mode the day rolls over after the pm half only
                  if (hour_format_bit) begin
                     next_pm = !afternoon_bit;
                  end
                  if (!hour_format_bit || afternoon_bit) begin
                     next_weekday = (weekday_reg == `WK_LAST) ? 3'h0 : weekday_reg + 3'h1;
                  end
               end
            end
         end
      end else if (wr_ok) begin
         unique case (wr_sel)
            `SEL_SECONDS:     next_seconds = wr_data[5:0];
            `SEL_MINUTES:     next_minutes = wr_data[5:0];
            `SEL_HOURS:       next_hours   = wr_data[4:0];
            `SEL_WEEKDAY:     next_weekday = wr_data[2:0];
            `SEL_FORMAT: begin
               next_format = wr_data[`FMT_H12_BIT];
               next_pm     = wr_data[`FMT_PM_BIT];
            end
            `SEL_SOURCE:      next_source  = wr_data[3:0];
            `SEL_CONTROL_TWO: next_ctl_two = wr_data;
            default:          next_ctl_two = timer_control_two;
         endcase
      end
   end

   // request flag: a set in the same cycle as a clear wins
   always_comb begin
      next_irq = irq_request_flag;
      if (irq_clear) begin
         next_irq = 1'b0;
      end
      if (update_now) begin
         next_irq = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         presc             <= '0;
         busy_cnt          <= '0;
         state             <= rtc_pkg::ST_IDLE;
         seconds_reg       <= 6'h00;
         minutes_reg       <= 6'h00;
         hours_reg         <= 5'h00;
         weekday_reg       <= 3'h0;
         hour_format_bit   <= 1'b0;
         afternoon_bit     <= 1'b0;
         count_source_bits <= 4'h0;
         timer_control_two <= 8'h00;
         update_busy_flag  <= 1'b0;
         irq_request_flag  <= 1'b0;
         timer_stopped     <= 1'b1;
         wr_refused        <= 1'b0;
      end else begin
         presc             <= next_presc;
         busy_cnt          <= next_busy_cnt;
         state             <= next_state;
         seconds_reg       <= next_seconds;
         minutes_reg       <= next_minutes;
         hours_reg         <= next_hours;
         weekday_reg       <= next_weekday;
         hour_format_bit   <= next_format;
         afternoon_bit     <= next_pm;
         count_source_bits <= next_source;
         timer_control_two <= next_ctl_two;
         update_busy_flag  <= next_busy;
         irq_request_flag  <= next_irq;
         timer_stopped     <= next_stopped;
         wr_refused        <= next_refused;
      end
   end

   // helper: source ticks seen while start bit and status disagree
   logic [1:0] lag_ticks;
   always_ff @(posedge sys_clk) begin
      if (srst || count_start_bit == sync_flag) begin
         lag_ticks <= 2'h0;
      end else if (tick && lag_ticks != 2'h3) begin
         lag_ticks <= lag_ticks + 2'h1;
      end
   end

   // helper: length of the current busy pulse in clocks
   logic [`BUSY_W-1:0] busy_len;
   always_ff @(posedge sys_clk) begin
      if (srst || !update_busy_flag) begin
         busy_len <= '0;
      end else begin
         busy_len <= busy_len + `BUSY_W'(1);
      end
   end

   a_rise_within_two: assert property (@(posedge sys_clk) disable iff (srst)
      (count_start_bit && !sync_flag) |-> lag_ticks <= `MISMATCH_MAX)
      else $error("status flag slow to follow start");
   a_fall_within_two: assert property (@(posedge sys_clk) disable iff (srst)
      (!count_start_bit && sync_flag) |-> lag_ticks <= `MISMATCH_MAX)
      else $error("status flag slow to clear");
   a_stopped_meaning: assert property (@(posedge sys_clk) disable iff (srst)
      ##1 timer_stopped == (!$past(count_start_bit) && !$past(sync_flag)))
      else $error("stopped flag wrong");
   a_write_refused: assert property (@(posedge sys_clk) disable iff (srst)
      (wr_en && !timer_stopped && state != rtc_pkg::ST_DONE) |=> wr_refused
      && $stable(count_source_bits) && $stable(timer_control_two))
      else $error("write accepted while running");
   a_busy_hold_min: assert property (@(posedge sys_clk) disable iff (srst)
      $fell(update_busy_flag) |-> busy_len == `BUSY_W'(BUSY_CYCLES + 1))
      else $error("busy pulse length wrong");
   a_busy_hold_start: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(update_busy_flag) |-> update_busy_flag[*2])
      else $error("busy dropped early");
   a_pm_stable_busy: assert property (@(posedge sys_clk) disable iff (srst)
      (update_busy_flag && state == rtc_pkg::ST_BUSY && !wr_en) |=> $stable(afternoon_bit)
      && $stable(seconds_reg))
      else $error("time changed inside busy");
   a_irq_on_update: assert property (@(posedge sys_clk) disable iff (srst)
      $fell(update_busy_flag) |-> irq_request_flag)
      else $error("no request flag at update");
   a_flag_follows: assert property (@(posedge sys_clk) disable iff (srst)
      $changed(sync_flag) |-> sync_flag == $past(u_sync.stage_one))
      else $error("status not from synchroniser");

   c_start_run: cover property (@(posedge sys_clk) disable iff (srst) $rose(sync_flag));
   c_update: cover property (@(posedge sys_clk) disable iff (srst) $fell(update_busy_flag));
   c_refused: cover property (@(posedge sys_clk) disable iff (srst) wr_refused);
   c_set_clear: cover property (@(posedge sys_clk) disable iff (srst)
      update_now && irq_clear);
endmodule

/* bench/test_rtc_run_control.sv */
// self-checking bench for the rtc run control and time readout block
`timescale 1ns/100ps
module test_rtc_run_control;
   localparam int BUSY = 8;
   localparam int TPS  = 16;
   // write data limits per select code, keeps time values in range and 24 h mode
   localparam logic [55:0] LIM = {8'hff, 8'h0f, 8'h02, 8'h03, 8'h0f, 8'h1f, 8'h1f};
   // clock, reset and stimulus
   logic       sys_clk         = 1'b0;
   logic       srst            = 1'b1;
   logic [3:0] count_ticks     = 4'h0;
   logic       count_start_bit = 1'b0;
   logic       wr_en           = 1'b0;
   logic [2:0] wr_sel          = 3'h0;
   logic [7:0] wr_data         = 8'h00;
   logic       irq_clear       = 1'b0;
   // observed outputs
   logic       count_status_flag;
   logic       timer_stopped;
   logic       wr_refused;
   logic [5:0] seconds_reg;
   logic [5:0] minutes_reg;
   logic [4:0] hours_reg;
   logic [2:0] weekday_reg;
   logic       hour_format_bit;
   logic       afternoon_bit;
   logic [3:0] count_source_bits;
   logic [7:0] timer_control_two;
   logic       update_busy_flag;
   logic       irq_request_flag;
   // bench state
   int         fails    = 0;
   int         n_checks = 0;
   int         seed     = 78;
   int         n;
   int         qid [$];
   logic [7:0] qexp [$];
   logic [7:0] val [7];
   logic [3:0] src;
   logic [7:0] rd;

   // short busy and second counts keep the run brief
   rtc_run_control #(.BUSY_CYCLES(BUSY), .TICKS_PER_SEC(TPS)) DUT (
      .sys_clk           (sys_clk),
      .srst              (srst),
      .count_ticks       (count_ticks),
      .count_start_bit   (count_start_bit),
      .count_status_flag (count_status_flag),
      .timer_stopped     (timer_stopped),
      .wr_en             (wr_en),
      .wr_sel            (wr_sel),
      .wr_data           (wr_data),
      .wr_refused        (wr_refused),
      .seconds_reg       (seconds_reg),
      .minutes_reg       (minutes_reg),
      .hours_reg         (hours_reg),
      .weekday_reg       (weekday_reg),
      .hour_format_bit   (hour_format_bit),
      .afternoon_bit     (afternoon_bit),
      .count_source_bits (count_source_bits),
      .timer_control_two (timer_control_two),
      .update_busy_flag  (update_busy_flag),
      .irq_clear         (irq_clear),
      .irq_request_flag  (irq_request_flag)
   );

   // 125 MHz clock
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end

   // picks the output that a queued note refers to
   function automatic logic [7:0] obs(input int id);
      case (id)
         0: obs = {7'h00, count_status_flag};
         1: obs = {7'h00, timer_stopped};
         2: obs = {7'h00, wr_refused};
         3: obs = {2'h0, seconds_reg};
         4: obs = {2'h0, minutes_reg};
         5: obs = {3'h0, hours_reg};
         6: obs = {5'h00, weekday_reg};
         7: obs = {6'h00, afternoon_bit, hour_format_bit};
         8: obs = {4'h0, count_source_bits};
         9: obs = timer_control_two;
         10: obs = {7'h00, update_busy_flag};
         default: obs = {7'h00, irq_request_flag};
      endcase
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic expect_val(input int id, input logic [7:0] exp);
      qid.push_back(id);
      qexp.push_back(exp);
   endtask

   // one-cycle pulse on the given tick lines
   task automatic tick(input logic [3:0] m);
      @(negedge sys_clk);
      count_ticks = m;
      @(negedge sys_clk);
      count_ticks = 4'h0;
   endtask

   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      @(negedge sys_clk);
      wr_en = 1'b1;
      wr_sel = s;
      wr_data = d;
      @(negedge sys_clk);
      wr_en = 1'b0;
   endtask

   // ticks the selected source until an update starts, then counts its busy clocks
   task automatic run_update(output int len);
      int k;
      k = 0;
      while (update_busy_flag !== 1'b1 && k < 3 * TPS) begin
         tick(src);
         k++;
      end
      expect_val(10, 8'h01);
      len = 0;
      while (update_busy_flag === 1'b1 && len < 100) begin
         @(negedge sys_clk);
         len++;
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // monitor: compares all queued notes once outputs have settled after the drive edge
   initial begin
      forever begin
         @(negedge sys_clk);
         #1;
         while (qid.size() > 0) chk(obs(qid.pop_front()), qexp.pop_front());
      end
   end

   // watchdog, far beyond the expected run of a few hundred cycles
   initial begin
      #(8 * 20000);
      fails++;
      end_sim;
   end

   initial begin
      repeat (12) @(negedge sys_clk);
      srst = 1'b0;
      expect_val(1, 8'h01);
      expect_val(0, 8'h00);
      // every write target while stopped, random data within range
      for (int s = 0; s < 7; s++) begin
         val[s] = 8'($random(seed)) & LIM[s*8 +: 8];
         wr(s[2:0], val[s]);
         expect_val(s + 3, val[s]);
      end
      src = 4'h1 << val[5][1:0];
      count_start_bit = 1'b1;
      @(negedge sys_clk);
      expect_val(1, 8'h00);
      // ticks of unselected sources must not move the synchroniser; nothing else is touched
      tick(~src);
      tick(src);
      expect_val(0, 8'h00);
      tick(src);
      repeat (2) @(negedge sys_clk);
      expect_val(0, 8'h01);
      // write while running is refused and leaves the register alone
      wr(3'h0, 8'h2a);
      expect_val(2, 8'h01);
      @(negedge sys_clk);
      expect_val(3, val[0]);
      // tick until a second boundary starts an update
      run_update(n);
      chk(8'(n), 8'(BUSY + 1));
      // read straight after the request flag, several registers in the same cycle
      expect_val(3, val[0] + 8'h01);
      expect_val(4, val[1]);
      expect_val(11, 8'h01);
      irq_clear = 1'b1;
      @(negedge sys_clk);
      irq_clear = 1'b0;
      expect_val(11, 8'h00);
      // a polling reader takes seconds only when two reads in a row agree
      n = 0;
      do begin
         rd = {2'h0, seconds_reg};
         @(negedge sys_clk);
         n++;
      end while (rd !== {2'h0, seconds_reg} && n < 4);
      expect_val(3, val[0] + 8'h01);
      // stop: the flag lags, so the timer is not yet stopped
      count_start_bit = 1'b0;
      @(negedge sys_clk);
      expect_val(1, 8'h00);
      tick(src);
      tick(src);
      repeat (2) @(negedge sys_clk);
      expect_val(0, 8'h00);
      @(negedge sys_clk);
      expect_val(1, 8'h01);
      wr(3'h1, 8'h11);
      expect_val(4, 8'h11);
      expect_val(2, 8'h00);
      // 12-hour mode: 11:59:59 pm rolls to 00:00:00 am and advances the weekday
      wr(3'h0, 8'h3b);
      wr(3'h1, 8'h3b);
      wr(3'h2, 8'h0b);
      wr(3'h3, 8'h06);
      wr(3'h4, 8'h03);
      wr(3'h6, 8'h01);
      expect_val(7, 8'h03);
      count_start_bit = 1'b1;
      // only the flag may be watched until it follows the start bit
      tick(src);
      tick(src);
      expect_val(0, 8'h01);
      run_update(n);
      chk(8'(n), 8'(BUSY + 1));
      expect_val(3, 8'h00);
      expect_val(4, 8'h00);
      expect_val(5, 8'h00);
      expect_val(7, 8'h01);
      expect_val(6, 8'h00);
      repeat (2) @(negedge sys_clk);
      end_sim;
   end
endmodule
